// ---- logic/guest_bus_code_feeder.sv ----
// Auxiliary bus master with cyclic code fetch, post path and general pins.
// Assumes a one-byte memory read port that answers with mem_ack and data,
// and peers on the auxiliary bus that may stretch strobes by guest_wait_n.
`timescale 1ns/1ps

// Behaviour
// RQ1: general pins come up as inputs
// RQ2: any guest selectable as code target
// RQ3: per-guest strobe/recovery counts at 0x030
// RQ4: software programs decoder counts 3 and 4
// RQ5: software programs encoder counts 12 and 15
// RQ6: eight byte addresses per guest
// RQ7: code fetch uses base, size, step
// RQ8: fetching starts only with enable set
// RQ9: fetch address wraps at buffer end
// RQ10: interrupt on each report step crossing
// RQ11: fetch pointer readable by host
// RQ12: fetched bytes buffered, written to target
// RQ13: decoder configured 8-bit, burst 2 or 4
// RQ14: peer setup traffic goes via post path
// RQ15: index then data cycle by address bit
// RQ16: programmable sync polarity on video input
// RQ17: wait sampled one clock before expiry
// RQ18: strobe low never beyond 32 clocks
// RQ19: strobe low duration, high recovery
module guest_bus_code_feeder (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [31:0]                reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output      logic [31:0]                reg_rdata,
	output      aux_bus_pkg::mem_req_t      mem,
	input  wire logic                       mem_ack,
	input  wire logic [7:0]                 mem_data,
	output      aux_bus_pkg::aux_bus_out_t  aux,
	input  wire logic [7:0]                 guest_data_in,
	input  wire logic                       guest_wait_n,
	input  wire logic [7:0]                 general_io_in,
	output      logic [7:0]                 general_io_out,
	output      logic [7:0]                 general_io_oe,
	input  wire logic                       hsync_in,
	input  wire logic                       vsync_in,
	output      logic                       hsync,
	output      logic                       vsync,
	output      logic                       irq
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [31:0]             code_ctrl;
	logic [31:0]             code_base;
	logic [31:0]             guest_timing_control;
	logic [1:0]              sync_pol;
	logic [1:0]              irq_status;
	logic [1:0]              irq_mask;
	logic                    post_pend;
	logic [13:0]             post_cmd;
	logic [7:0]              post_rdata;
	logic [14:0]             code_ptr;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_dir    = reg_wr && (reg_addr == aux_bus_pkg::OFS_GPIO_DIR);
	wire wr_level  = reg_wr && (reg_addr == aux_bus_pkg::OFS_GPIO_LEVEL);
	wire wr_ctrl   = reg_wr && (reg_addr == aux_bus_pkg::OFS_CODE_CTRL);
	wire wr_base   = reg_wr && (reg_addr == aux_bus_pkg::OFS_CODE_BASE);
	wire wr_post   = reg_wr && (reg_addr == aux_bus_pkg::OFS_POST);
	wire wr_pol    = reg_wr && (reg_addr == aux_bus_pkg::OFS_SYNC_POL);
	wire wr_mask   = reg_wr && (reg_addr == aux_bus_pkg::OFS_IRQ_MASK);
	wire wr_timing = reg_wr && (reg_addr == aux_bus_pkg::OFS_GUEST_TIMING);
	wire rd_status = reg_rd && (reg_addr == aux_bus_pkg::OFS_IRQ_STATUS);

	// Code fetch settings
	wire       fetch_en   = code_ctrl[aux_bus_pkg::CTRL_EN_BIT];
	wire [1:0] code_tgt   = code_ctrl[aux_bus_pkg::CTRL_TGT_LSB +: 2];
	wire [1:0] size_sel   = code_ctrl[aux_bus_pkg::CTRL_SIZE_LSB +: 2];
	wire [1:0] step_sel   = code_ctrl[aux_bus_pkg::CTRL_STEP_LSB +: 2];
	wire [15:0] size_mask = (aux_bus_pkg::CODE_BUF_MIN << size_sel) - 16'h0001;
	wire [15:0] step_mask = (aux_bus_pkg::STEP_MIN << step_sel) - 16'h0001;

	// Read mux; unmapped offsets read zero
	logic [31:0] next_rdata;
	always_comb begin
		case (reg_addr)
		aux_bus_pkg::OFS_GPIO_DIR:     next_rdata = {24'h0, general_io_oe};
		aux_bus_pkg::OFS_GPIO_LEVEL:   next_rdata = {24'h0, general_io_out};
		aux_bus_pkg::OFS_GPIO_PINS:    next_rdata = {24'h0, general_io_in};
		aux_bus_pkg::OFS_CODE_CTRL:    next_rdata = code_ctrl;
		aux_bus_pkg::OFS_CODE_BASE:    next_rdata = code_base;
		aux_bus_pkg::OFS_CODE_PTR:     next_rdata = {17'h0, code_ptr}; // [RQ11]
		aux_bus_pkg::OFS_POST:         next_rdata = {post_pend, 23'h0, post_rdata};
		aux_bus_pkg::OFS_SYNC_POL:     next_rdata = {30'h0, sync_pol};
		aux_bus_pkg::OFS_IRQ_STATUS:   next_rdata = {30'h0, irq_status};
		aux_bus_pkg::OFS_IRQ_MASK:     next_rdata = {30'h0, irq_mask};
		aux_bus_pkg::OFS_GUEST_TIMING: next_rdata = guest_timing_control;
		default:                       next_rdata = 32'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Host registers
	// ----------------------------------------------------------------
	// Pins start as inputs so peer resets stay on their pull-downs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			general_io_oe        <= aux_bus_pkg::RST_GPIO_DIR; // [RQ1]
			general_io_out       <= 8'h00;
			code_ctrl            <= 32'h0;
			code_base            <= 32'h0;
			guest_timing_control <= aux_bus_pkg::RST_TIMING;
			sync_pol             <= 2'b00;
			irq_mask             <= 2'b00;
			reg_rdata            <= 32'h0;
		end else begin
			if (wr_dir)    general_io_oe  <= reg_wdata[7:0]; // [RQ1]
			if (wr_level)  general_io_out <= reg_wdata[7:0]; // [RQ1]
			if (wr_ctrl)   code_ctrl <= reg_wdata; // [RQ2] [RQ7] [RQ8]
			if (wr_base)   code_base <= reg_wdata; // [RQ7]
			if (wr_timing) guest_timing_control <= reg_wdata; // [RQ3]
			if (wr_pol)    sync_pol <= reg_wdata[1:0];
			if (wr_mask)   irq_mask <= reg_wdata[1:0];
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
		end
	end

	// Sync inputs normalised to active high before capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hsync <= 1'b0;
			vsync <= 1'b0;
		end else begin
			hsync <= hsync_in ^ sync_pol[aux_bus_pkg::SYNC_H_BIT]; // [RQ16]
			vsync <= vsync_in ^ sync_pol[aux_bus_pkg::SYNC_V_BIT]; // [RQ16]
		end
	end

	// ----------------------------------------------------------------
	// Internal code buffer, four bytes of flip-flops
	// ----------------------------------------------------------------
	logic [7:0] fifo_mem [4];
	logic [2:0] wptr;
	logic [2:0] rptr;
	wire        fifo_full  = (wptr ^ rptr) == 3'b100;
	wire        fifo_empty = wptr == rptr;
	wire        push       = mem.req && mem_ack;
	logic       pop;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					fifo_mem[gi] <= 8'h00;
				else if (push && wptr[1:0] == 2'(gi))
					fifo_mem[gi] <= mem_data; // [RQ12]
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Cyclic code fetch
	// ----------------------------------------------------------------
	// One fetch in flight; full buffer holds off the next request
	wire [15:0] ptr_inc    = {1'b0, code_ptr} + 16'h0001;
	wire [15:0] ptr_wrap   = ptr_inc & size_mask;
	wire        step_cross = (ptr_inc & step_mask) == 16'h0000;
	wire [31:0] fetch_addr = code_base + {16'h0, ptr_wrap};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem      <= '0;
			code_ptr <= 15'h0;
			wptr     <= 3'h0;
		end else begin
			if (push) begin
				mem.req  <= 1'b0;
				mem.addr <= fetch_addr; // [RQ9]
				code_ptr <= ptr_wrap[14:0]; // [RQ9]
				wptr     <= wptr + 3'h1;
			end else if (fetch_en && !mem.req && !fifo_full) begin
				mem.req <= 1'b1; // [RQ8]
			end else if (!fetch_en && !mem.req) begin
				code_ptr <= 15'h0;
				mem.addr <= code_base; // [RQ7]
			end
		end
	end

	// ----------------------------------------------------------------
	// Auxiliary bus master
	// ----------------------------------------------------------------
	aux_bus_pkg::aux_state_t state;
	logic [1:0] cur_guest;
	logic       cur_post;
	logic [4:0] cnt;
	logic [5:0] low;

	wire [7:0] cur_tim  = guest_timing_control[cur_guest
	               * aux_bus_pkg::TIM_GUEST_W +: 8]; // [RQ3]
	wire [4:0] dur      = {1'b0, cur_tim[aux_bus_pkg::TIM_DUR_LSB +: 4]};
	wire [4:0] rec      = {1'b0, cur_tim[aux_bus_pkg::TIM_REC_LSB +: 4]};
	wire       strobe_end = cnt >= dur; // [RQ19]
	// Wait looked at only in the last-but-one strobe clock
	wire       hold = (cnt + 5'h01 == dur) && !guest_wait_n
	               && (low < aux_bus_pkg::STROBE_MAX - 6'h01); // [RQ17] [RQ18]
	wire [1:0] post_guest = post_cmd[aux_bus_pkg::POST_GUEST_LSB +: 2];
	wire       take_post  = state == aux_bus_pkg::ST_IDLE && post_pend;
	assign pop = state == aux_bus_pkg::ST_IDLE && !post_pend && !fifo_empty;
	wire       post_done  = state == aux_bus_pkg::ST_STROBE && strobe_end
	               && cur_post;

	// Post path has priority so setup traffic is never starved by code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= aux_bus_pkg::ST_IDLE;
			aux       <= '{cs_n: 4'hf, addr: 3'h0, wr_n: 1'b1, rd_n: 1'b1,
			               data: 8'h00, data_oe: 1'b0};
			cur_guest <= 2'h0;
			cur_post  <= 1'b0;
			cnt       <= 5'h0;
			low       <= 6'h0;
			rptr      <= 3'h0;
		end else begin
			case (state)
			aux_bus_pkg::ST_IDLE: begin
				if (take_post) begin // [RQ14]
					cur_guest <= post_guest;
					cur_post  <= 1'b1;
					aux.cs_n  <= ~(4'h1 << post_guest);
					aux.addr  <= post_cmd[aux_bus_pkg::POST_ADDR_LSB +: 3]; // [RQ6] [RQ15]
					aux.data  <= post_cmd[aux_bus_pkg::POST_DATA_LSB +: 8];
					aux.data_oe <= !post_cmd[aux_bus_pkg::POST_READ_BIT];
					state     <= aux_bus_pkg::ST_SETUP;
				end else if (pop) begin // [RQ12]
					cur_guest <= code_tgt;
					cur_post  <= 1'b0;
					aux.cs_n  <= ~(4'h1 << code_tgt); // [RQ2]
					aux.addr  <= aux_bus_pkg::CODE_PORT_ADDR;
					aux.data  <= fifo_mem[rptr[1:0]];
					aux.data_oe <= 1'b1;
					rptr      <= rptr + 3'h1;
					state     <= aux_bus_pkg::ST_SETUP;
				end
			end
			aux_bus_pkg::ST_SETUP: begin
				aux.wr_n <= !aux.data_oe;
				aux.rd_n <= aux.data_oe;
				cnt      <= 5'h1;
				low      <= 6'h1;
				state    <= aux_bus_pkg::ST_STROBE;
			end
			aux_bus_pkg::ST_STROBE: begin
				if (strobe_end) begin // [RQ19]
					aux.wr_n <= 1'b1;
					aux.rd_n <= 1'b1;
					cnt      <= 5'h1;
					state    <= aux_bus_pkg::ST_RECOVER;
				end else begin
					low <= low + 6'h01;
					if (!hold)
						cnt <= cnt + 5'h01; // [RQ17]
				end
			end
			aux_bus_pkg::ST_RECOVER: begin
				// Select released late for hold time on the peer
				aux.cs_n    <= 4'hf;
				aux.data_oe <= 1'b0;
				cnt         <= cnt + 5'h01;
				if (cnt >= rec)
					state <= aux_bus_pkg::ST_IDLE; // [RQ19]
			end
			default: state <= aux_bus_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Post path and interrupt status
	// ----------------------------------------------------------------
	// Writes while busy are dropped; software polls the busy bit
	wire [1:0] events = {post_done, push && step_cross}; // [RQ10]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			post_pend  <= 1'b0;
			post_cmd   <= 14'h0;
			post_rdata <= 8'h00;
			irq_status <= 2'b00;
			irq        <= 1'b0;
		end else begin
			if (wr_post && !post_pend) begin
				post_pend <= 1'b1; // [RQ14]
				post_cmd  <= reg_wdata[13:0];
			end else if (post_done) begin
				post_pend <= 1'b0;
			end
			if (post_done && !aux.data_oe)
				post_rdata <= guest_data_in; // [RQ15]
			// Set beats the clear of a status read
			irq_status <= events | (irq_status & {2{!rd_status}}); // [RQ10]
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule

// ---- logic/aux_bus_pkg.sv ----
// Constants, types and register map of the auxiliary bus code feeder.
// Assumes a single clock domain and a plain register port on the host side.
package aux_bus_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_GPIO_DIR     = 8'h00;
	localparam logic [7:0] OFS_GPIO_LEVEL   = 8'h04;
	localparam logic [7:0] OFS_GPIO_PINS    = 8'h08;
	localparam logic [7:0] OFS_CODE_CTRL    = 8'h0c;
	localparam logic [7:0] OFS_CODE_BASE    = 8'h10;
	localparam logic [7:0] OFS_CODE_PTR     = 8'h14;
	localparam logic [7:0] OFS_POST         = 8'h18;
	localparam logic [7:0] OFS_SYNC_POL     = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h24;
	localparam logic [7:0] OFS_GUEST_TIMING = 8'h30;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_TGT_LSB   = 1;
	localparam int CTRL_SIZE_LSB  = 4;
	localparam int CTRL_STEP_LSB  = 8;
	localparam int POST_DATA_LSB  = 0;
	localparam int POST_ADDR_LSB  = 8;
	localparam int POST_GUEST_LSB = 11;
	localparam int POST_READ_BIT  = 13;
	localparam int POST_BUSY_BIT  = 31;
	localparam int TIM_DUR_LSB    = 0;
	localparam int TIM_REC_LSB    = 4;
	localparam int TIM_GUEST_W    = 8;
	localparam int SYNC_H_BIT     = 0;
	localparam int SYNC_V_BIT     = 1;
	localparam int IRQ_STEP_BIT   = 0;
	localparam int IRQ_POST_BIT   = 1;

	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_GPIO_DIR   = 8'h00;
	localparam logic [31:0] RST_TIMING     = 32'hffffffff;
	localparam logic [15:0] CODE_BUF_MIN   = 16'h1000;
	localparam logic [15:0] STEP_MIN       = 16'h0200;
	localparam logic [2:0]  CODE_PORT_ADDR = 3'h0;
	localparam logic [5:0]  STROBE_MAX     = 6'h20;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SETUP   = 2'b01,
		ST_STROBE  = 2'b10,
		ST_RECOVER = 2'b11
	} aux_state_t;

	typedef struct packed {
		logic [3:0] cs_n;
		logic [2:0] addr;
		logic       wr_n;
		logic       rd_n;
		logic [7:0] data;
		logic       data_oe;
	} aux_bus_out_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} mem_req_t;

endpackage

// ---- dv/guest_bus_code_feeder_sva.sv ----
// Port-level checker for the auxiliary bus code feeder.
// Assumes one clock and an async low reset; bound below to the feeder.
`timescale 1ns/1ps
module feeder_checker (
	input wire logic                      clk,
	input wire logic                      rst_n,
	input wire logic [7:0]                reg_addr,
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [31:0]               reg_rdata,
	input wire aux_bus_pkg::mem_req_t     mem,
	input wire logic                      mem_ack,
	input wire aux_bus_pkg::aux_bus_out_t aux,
	input wire logic [7:0]                general_io_oe,
	input wire logic                      hsync_in,
	input wire logic                      hsync
);
	// ------------------------------------------------------------
	// Strobe length counter
	// ------------------------------------------------------------
	wire        strobe_low = !aux.wr_n || !aux.rd_n;
	logic [5:0] lo_cnt;
	logic [5:0] next_lo_cnt;
	// Counts low cycles; a stuck strobe trips the cap long before wrap
	assign next_lo_cnt = strobe_low ? lo_cnt + 6'h01 : 6'h00;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lo_cnt <= 6'h00;
		else
			lo_cnt <= next_lo_cnt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its answer cycle");
	property p_dir_only;
		!(reg_wr && reg_addr == aux_bus_pkg::OFS_GPIO_DIR)
			|=> $stable(general_io_oe);
	endproperty
	a_dir_only: assert property (p_dir_only)
		else $error("pin direction changed without a write");
	property p_req_hold;
		mem.req && !mem_ack |=> mem.req && $stable(mem.addr);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("fetch request dropped or moved early");
	property p_req_drop;
		mem.req && mem_ack |=> !mem.req;
	endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("fetch request kept after answer");
	property p_one_guest;
		$onehot0(~aux.cs_n);
	endproperty
	a_one_guest: assert property (p_one_guest)
		else $error("more than one guest selected");
	property p_frame;
		strobe_low |-> aux.cs_n != 4'hf && $stable(aux.cs_n)
			&& $stable(aux.addr);
	endproperty
	a_frame: assert property (p_frame)
		else $error("select or address moved under strobe");
	property p_write_drive;
		!aux.wr_n |-> aux.data_oe && $stable(aux.data);
	endproperty
	a_write_drive: assert property (p_write_drive)
		else $error("write data not held under strobe");
	property p_recovery;
		$rose(aux.wr_n & aux.rd_n) |-> (aux.wr_n & aux.rd_n) [*3];
	endproperty
	a_recovery: assert property (p_recovery)
		else $error("strobe high time too short");
	property p_strobe_cap;
		lo_cnt <= 6'h20;
	endproperty
	a_strobe_cap: assert property (p_strobe_cap)
		else $error("strobe low beyond cap");
	property p_sync;
		$changed(hsync_in) && !reg_wr && !$past(reg_wr)
			|=> $changed(hsync);
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync output did not follow input");
endmodule

bind guest_bus_code_feeder feeder_checker chk_i (.clk, .rst_n, .reg_addr,
	.reg_wr, .reg_rd, .reg_rdata, .mem, .mem_ack, .aux, .general_io_oe,
	.hsync_in, .hsync);

// ---- dv/aux_peer_model.sv ----
// Far side: a one-byte system memory port and the guest peers.
// Assumes the feeder drives mem and aux from registers on clk.
`timescale 1ns/1ps
module aux_peer_model (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire aux_bus_pkg::mem_req_t     mem,
	output      logic                      mem_ack,
	output      logic [7:0]                mem_data,
	input  wire aux_bus_pkg::aux_bus_out_t aux,
	output      logic [7:0]                guest_data_in,
	output      logic                      guest_wait_n,
	input  wire logic                      stall,
	input  wire logic [5:0]                wait_len
);
	wire         strobe_low = !aux.wr_n || !aux.rd_n;
	logic [5:0]  lo_cnt;
	logic [5:0]  last_len;
	logic [15:0] cur;
	logic [14:0] wq[$];
	// Wait held for wait_len strobe cycles; the cap must cut it
	assign guest_wait_n = !(strobe_low && lo_cnt < wait_len);
	// Memory byte is a function of its address; stall withholds it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			mem_data <= 8'h00;
		end else if (mem.req && !mem_ack && !stall) begin
			mem_ack <= 1'b1;
			mem_data <= mem.addr[7:0] ^ 8'h5a;
		end else begin
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
		end
	end
	// Byte-wide port, split strobes, I/O space only
	// Read byte only under strobe, else a toggling pattern
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			guest_data_in <= 8'h00;
		else if (!aux.rd_n)
			guest_data_in <= 8'hc0 | {5'h00, aux.addr};
		else
			guest_data_in <= ~guest_data_in;
	end
	// Log each finished write and the strobe length
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_cnt <= 6'h00;
		end else if (strobe_low) begin
			lo_cnt <= lo_cnt + 6'h01;
			cur <= {aux.cs_n, aux.addr, aux.data, !aux.wr_n};
		end else if (lo_cnt != 6'h00) begin
			lo_cnt <= 6'h00;
			last_len <= lo_cnt;
			if (cur[0])
				wq.push_back(cur[15:1]);
		end
	end
endmodule

// ---- dv/guest_bus_code_feeder_bench.sv ----
// Self-checking bench for the auxiliary bus code feeder.
// Assumes the peer model on the far side and the bound checker.
`timescale 1ns/1ps
module guest_bus_code_feeder_bench;
	logic                      clk = 1'b0;
	logic                      rst_n = 1'b0;
	logic [7:0]                reg_addr = 8'h00;
	logic [31:0]               reg_wdata = 32'h0;
	logic                      reg_wr = 1'b0;
	logic                      reg_rd = 1'b0;
	logic [31:0]               reg_rdata;
	aux_bus_pkg::mem_req_t     mem;
	logic                      mem_ack;
	logic [7:0]                mem_data;
	aux_bus_pkg::aux_bus_out_t aux;
	logic [7:0]                guest_data_in;
	logic                      guest_wait_n;
	logic [7:0]                general_io_in = 8'ha5;
	logic [7:0]                general_io_out;
	logic [7:0]                general_io_oe;
	logic                      hsync_in = 1'b0;
	logic                      vsync_in = 1'b0;
	logic                      hsync;
	logic                      vsync;
	logic                      irq;
	logic                      stall = 1'b0;
	logic [5:0]                wait_len = 6'h00;
	int                        failures = 0;
	int                        n_compared = 0;
	logic [5:0]                dur_tab [4] = '{6'h01, 6'h03, 6'h0c, 6'h01};

	always #25 clk = ~clk;

	guest_bus_code_feeder DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .mem, .mem_ack, .mem_data, .aux, .guest_data_in,
		.guest_wait_n, .general_io_in, .general_io_out, .general_io_oe,
		.hsync_in, .vsync_in, .hsync, .vsync, .irq);
	aux_peer_model peer (.clk, .rst_n, .mem, .mem_ack, .mem_data, .aux,
		.guest_data_in, .guest_wait_n, .stall, .wait_len);

	// ------------------------------------------------------------
	// Register port tasks
	// ------------------------------------------------------------
	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	// Post a word, then poll busy under a bound
	task automatic post(input logic [31:0] w, output logic [31:0] d);
		d = 32'h80000000;
		wr(aux_bus_pkg::OFS_POST, w);
		for (int n = 0; n < 200 && d[31]; n++)
			rd(aux_bus_pkg::OFS_POST, d);
		if (d[31]) begin
			failures++;
			summarize();
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [14:0] e;
		int          i;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rdc(aux_bus_pkg::OFS_GPIO_DIR, 32'h0);
		chk(32'(general_io_oe), 32'h0);
		rdc(aux_bus_pkg::OFS_GUEST_TIMING, 32'hffffffff);
		rdc(8'h3c, 32'h0);
		wr(aux_bus_pkg::OFS_GPIO_DIR, 32'h81);
		wr(aux_bus_pkg::OFS_GPIO_LEVEL, 32'h01);
		@(negedge clk);
		chk(32'({general_io_oe, general_io_out}), 32'h8101);
		rdc(aux_bus_pkg::OFS_GPIO_PINS, 32'ha5);
		// Decoder on guest 1, encoder on guest 2
		wr(aux_bus_pkg::OFS_GUEST_TIMING, 32'h11fc4311);
		rdc(aux_bus_pkg::OFS_GUEST_TIMING, 32'h11fc4311);
		wr(aux_bus_pkg::OFS_IRQ_MASK, 32'h3);
		// Index then data to every guest, two addresses each
		for (int g = 0; g < 4; g++)
			for (int j = 0; j < 2; j++) begin
				post({19'h0, 2'(g), 3'(2 * g + j), 8'(16 * g + j)}, d);
				e = peer.wq.pop_front();
				chk(32'(e), 32'({~(4'h1 << g), 3'(2 * g + j),
					8'(16 * g + j)}));
				chk(32'(peer.last_len), 32'(dur_tab[g]));
			end
		post(32'h2f00, d);
		chk(d, 32'hc7);
		chk(32'(irq), 32'h1);
		rdc(aux_bus_pkg::OFS_IRQ_STATUS, 32'h2);
		@(negedge clk);
		chk(32'(irq), 32'h0);
		// A peer that never releases wait; guest 1 samples it
		@(posedge clk);
		wait_len <= 6'h28;
		post(32'h0800, d);
		chk(32'(peer.last_len), 32'h20);
		e = peer.wq.pop_front();
		chk(32'(e), 32'({4'hd, 3'h0, 8'h00}));
		rdc(aux_bus_pkg::OFS_IRQ_STATUS, 32'h2);
		@(posedge clk);
		wait_len <= 6'h00;
		hsync_in <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({hsync, vsync}), 32'h2);
		wr(aux_bus_pkg::OFS_SYNC_POL, 32'h3);
		repeat (2) @(posedge clk);
		chk(32'({hsync, vsync}), 32'h1);
		// Cyclic fetch to guest 1, 4K buffer, 512-byte steps
		wr(aux_bus_pkg::OFS_CODE_BASE, 32'h2000);
		wr(aux_bus_pkg::OFS_CODE_CTRL, 32'h2);
		repeat (10) @(posedge clk);
		chk(32'(mem.req), 32'h0);
		wr(aux_bus_pkg::OFS_CODE_CTRL, 32'h3);
		for (i = 0; i < 4100; i++) begin
			for (int n = 0; n < 100 && peer.wq.size() == 0; n++)
				@(posedge clk);
			if (peer.wq.size() == 0) begin
				failures++;
				summarize();
			end
			e = peer.wq.pop_front();
			chk(32'(e), 32'({4'hd, 3'h0, 8'(i) ^ 8'h5a}));
			if (i == 520) begin
				chk(32'(irq), 32'h1);
				rdc(aux_bus_pkg::OFS_IRQ_STATUS, 32'h1);
			end
			if (i == 530)
				chk(32'(irq), 32'h0);
		end
		// Memory stalls; drain and read where the pointer stopped
		stall <= 1'b1;
		repeat (60) @(posedge clk);
		while (peer.wq.size() > 0) begin
			e = peer.wq.pop_front();
			i++;
		end
		rdc(aux_bus_pkg::OFS_CODE_PTR, 32'(i % 4096));
		chk(mem.addr, 32'h2000 + 32'(i % 4096));
		summarize();
	end
endmodule
